// >>> tb/ifxi_partner.sv
// far-side model: interrupt source plus fp and cp exception units
`timescale 1ns/10ps
module ifxi_partner (
    input  wire logic       i_clk,
    input  wire logic       i_load,
    input  wire logic [3:0] i_value,
    input  wire logic       i_fp_raise,
    input  wire logic       i_cp_raise,
    input  wire logic       i_int_ack,
    input  wire logic       i_fp_ack,
    input  wire logic       i_cp_ack,
    output logic      [3:0] o_level,
    output logic            o_fp_n,
    output logic            o_cp_n
);
    localparam logic [2:0] FP_KIND = 3'h1; // arbitrary exception kind code
    logic [1:0] fp_queue;
    logic [1:0] cp_queue;
    logic [2:0] fp_kind;
    initial begin
        o_level = 4'h0;
        o_fp_n = 1'b1;
        o_cp_n = 1'b1;
        fp_queue = 2'h0;
        cp_queue = 2'h0;
        fp_kind = 3'h0;
    end
    ////////////////////////////////////////////////////////////////
    // a raise loads the queue with the faulting op in front and one started op behind;
    // exception mode lasts until the acknowledge; store-queue ops then drain it, one a clock, and a new
    // raise is refused until it is empty
    always @(posedge i_clk) begin
        if (i_load) o_level <= i_value;
        else if (i_int_ack) o_level <= 4'h0;
        if (i_fp_raise && fp_queue == 2'h0) begin
            o_fp_n   <= 1'b0;
            fp_queue <= 2'h2;
            fp_kind  <= FP_KIND;
        end else if (i_fp_ack) begin
            o_fp_n <= 1'b1;
        end else if (o_fp_n && fp_queue != 2'h0) begin
            fp_queue <= fp_queue - 2'h1;
        end
        if (i_cp_raise && cp_queue == 2'h0) begin
            o_cp_n   <= 1'b0;
            cp_queue <= 2'h2;
        end else if (i_cp_ack) begin
            o_cp_n <= 1'b1;
        end else if (o_cp_n && cp_queue != 2'h0) begin
            cp_queue <= cp_queue - 2'h1;
        end
    end
endmodule

// >>> tb/testbench.sv
// self-checking bench for the interrupt and exception intake
`timescale 1ns/10ps
module testbench;
    import ifxi_pkg::*;
    logic        clk, srst, ed, sy, fi, ci, an, bt, ld, fr, cr, fpn, cpn, ia, fa, ca, tk;
    logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [1:0]  bresp, rresp, r2;
    logic [2:0]  acks;
    logic [3:0]  val, lvl, lv, ws;
    logic [7:0]  tt, awa, ara;
    logic [31:0] pc, next_program_counter, bpc, tpc, r17, r18, wd, rd, d;
    int          bad_count, checked, cyc, tkn;
    logic        s, take, hd, hq;
    ifxi_intake i_ifxi_intake (.I_CLK_SYS(clk), .I_SRST(srst), .I_INTERRUPT_REQUEST_LEVEL(lvl),
        .I_FP_EXCEPTION_REQUEST_N(fpn), .I_CP_EXCEPTION_REQUEST_N(cpn), .I_EXEC_DONE(ed),
        .I_HOLD(hd), .I_SYNC_TRAP(sy), .I_FP_INSTR(fi), .I_CP_INSTR(ci), .I_ANNUL_BRANCH(an),
        .I_BRANCH_TAKEN(bt), .I_EXEC_PC(pc), .I_EXEC_NPC(next_program_counter), .I_BRANCH_PC(bpc),
        .I_TARGET_PC(tpc), .O_INTERRUPT_ACKNOWLEDGE(ia), .O_FP_EXCEPTION_ACKNOWLEDGE(fa),
        .O_CP_EXCEPTION_ACKNOWLEDGE(ca), .O_TRAP_TAKEN(tk), .O_TRAP_TYPE(tt), .O_SAVE_R17(r17),
        .O_SAVE_R18(r18), .I_AWVALID(awv), .I_AWADDR(awa), .O_AWREADY(awr), .I_WVALID(wv),
        .I_WDATA(wd), .I_WSTRB(ws), .O_WREADY(wr), .O_BVALID(bv), .O_BRESP(bresp),
        .I_BREADY(br), .I_ARVALID(arv), .I_ARADDR(ara), .O_ARREADY(arr), .O_RVALID(rv),
        .O_RDATA(rd), .O_RRESP(rresp), .I_RREADY(rr));
    ifxi_partner i_ifxi_partner (.i_clk(clk), .i_load(ld), .i_value(val), .i_fp_raise(fr),
        .i_cp_raise(cr), .i_int_ack(ia), .i_fp_ack(fa), .i_cp_ack(ca), .o_level(lvl),
        .o_fp_n(fpn), .o_cp_n(cpn));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] x, output logic [1:0] r);
        {awa, wd, awv, wv, br} <= {a, x, 3'b111};
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        r = bresp;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] x, output logic [1:0] r);
        {ara, arv, rr} <= {a, 2'b11};
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        x = rd;
        r = rresp;
    endtask
    // one execute completion, then watch four cycles for the trap pulse
    task automatic exec(input logic f, input logic c, input logic st, input logic b);
        {ed, fi, ci, sy} <= {1'b1, f, c, st};
        {pc, next_program_counter, bpc, tpc} <= {$urandom, $urandom, $urandom, $urandom};
        an <= b && $urandom_range(1, 0);
        bt <= b && $urandom_range(1, 0);
        @(posedge clk);
        ed <= 1'b0;
        // one hold cycle after the decision stretches only the annulled-branch slip
        hq = 1'($urandom_range(1, 0));
        hd <= hq;
        cyc = 0;
        tkn = 0;
        for (int j = 1; j < 5; j++) begin
            @(posedge clk);
            hd <= 1'b0;
            if (tk === 1'b1) begin
                tkn++;
                cyc = j;
                acks = {ia, fa, ca};
            end
        end
    endtask
    function automatic logic [31:0] save_exp(input logic second);
        if (an) return (bt ? tpc : bpc) + (second ? PC_STEP : 32'h0);
        return second ? (bt ? tpc : next_program_counter) : pc;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {srst, ed, sy, fi, ci, an, bt, ld, fr, cr, awv, wv, br, arv, rr, hd} = 16'h8000;
        {val, ws, awa, ara, wd, pc, next_program_counter, bpc, tpc} = {4'h0, 4'hF, 176'h0};
        void'($urandom(80));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        chk({ia, fa, ca, tk}, 0);
        axw(OFS_CTRL, 32'h51, r2);
        axr(OFS_CTRL, d, r2);
        chk(d, 32'h51);
        axr(8'h40, d, r2);
        chk(r2, RESP_SLVERR);
        axw(OFS_STATUS, 32'h0, r2);
        chk(r2, RESP_SLVERR);
        $display("registers done");
        // pil is 5: corners are nmi, equal to pil, just above, one-edge glitch
        for (int i = 0; i < 24; i++) begin
            lv = i == 0 ? 4'hF : i == 1 ? 4'h5 : i < 4 ? 4'h6 : 4'($urandom_range(15, 0));
            {ld, val} <= {1'b1, lv};
            @(posedge clk);
            {ld, val} <= {i == 3, 4'h0};
            @(posedge clk);
            ld <= 1'b0;
            repeat (6) @(posedge clk);
            s = i > 3 && $urandom_range(3, 0) == 0;
            exec(1'b0, 1'b0, s, 1'b1);
            take = lv > 4'h5 && !s && i != 3;
            chk(cyc, take ? (an ? 2 + hq : 1) : 0);
            if (take) begin
                chk(tkn, 1);
                chk(acks, 3'b100);
                chk(tt, TT_INT_BASE + lv);
                chk(r17, save_exp(1'b0));
                chk(r18, save_exp(1'b1));
            end
        end
        axw(OFS_CTRL, 32'h0, r2);
        {ld, val} <= {1'b1, 4'hF};
        repeat (8) @(posedge clk);
        exec(1'b0, 1'b0, 1'b0, 1'b0);
        chk(cyc, 0);
        ld <= 1'b1;
        val <= 4'h0;
        $display("interrupts done");
        for (int c = 0; c < 2; c++) begin
            {fr, cr} <= {c == 0, c == 1};
            @(posedge clk);
            {fr, cr, ld} <= 3'b000;
            repeat (4) @(posedge clk);
            exec(1'b0, 1'b0, 1'b0, 1'b0);
            chk(cyc, 0);
            exec(c == 0, c == 1, 1'b0, 1'b0);
            chk(cyc, 1);
            chk(acks, c ? 3'b001 : 3'b010);
            chk(tt, c ? TT_CP_EXC : TT_FP_EXC);
            chk(r17, pc);
            chk(r18, next_program_counter);
        end
        $display("exceptions done");
        tally_and_finish();
    end
endmodule

// >>> verilog/ifxi_intake.sv
// interrupt request and fp/cp exception intake of the integer unit
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module ifxi_intake
    import ifxi_pkg::*;
(
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_SRST,
    input  wire logic [3:0]  I_INTERRUPT_REQUEST_LEVEL,
    input  wire logic        I_FP_EXCEPTION_REQUEST_N,
    input  wire logic        I_CP_EXCEPTION_REQUEST_N,
    input  wire logic        I_EXEC_DONE,
    input  wire logic        I_HOLD,
    input  wire logic        I_SYNC_TRAP,
    input  wire logic        I_FP_INSTR,
    input  wire logic        I_CP_INSTR,
    input  wire logic        I_ANNUL_BRANCH,
    input  wire logic        I_BRANCH_TAKEN,
    input  wire logic [31:0] I_EXEC_PC,
    input  wire logic [31:0] I_EXEC_NPC,
    input  wire logic [31:0] I_BRANCH_PC,
    input  wire logic [31:0] I_TARGET_PC,
    output logic             O_INTERRUPT_ACKNOWLEDGE,
    output logic             O_FP_EXCEPTION_ACKNOWLEDGE,
    output logic             O_CP_EXCEPTION_ACKNOWLEDGE,
    output logic             O_TRAP_TAKEN,
    output logic      [7:0]  O_TRAP_TYPE,
    output logic      [31:0] O_SAVE_R17,
    output logic      [31:0] O_SAVE_R18,
    input  wire logic        I_AWVALID,
    input  wire logic [7:0]  I_AWADDR,
    output logic             O_AWREADY,
    input  wire logic        I_WVALID,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    output logic             O_WREADY,
    output logic             O_BVALID,
    output logic      [1:0]  O_BRESP,
    input  wire logic        I_BREADY,
    input  wire logic        I_ARVALID,
    input  wire logic [7:0]  I_ARADDR,
    output logic             O_ARREADY,
    output logic             O_RVALID,
    output logic      [31:0] O_RDATA,
    output logic      [1:0]  O_RRESP,
    input  wire logic        I_RREADY
);
    function automatic ifxi_sel_e decode(input logic [7:0] addr);
        case (addr)
            OFS_CTRL:      decode = SEL_CTRL;
            OFS_STATUS:    decode = SEL_STATUS;
            OFS_SAVED_PC:  decode = SEL_PC;
            OFS_SAVED_NPC: decode = SEL_NPC;
            OFS_TRAP_TYPE: decode = SEL_TT;
            default:       decode = SEL_NONE;
        endcase
    endfunction

    function automatic logic [31:0] step(input logic [31:0] pc);
        step = pc + PC_STEP;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [3:0]  acc_level;
    logic        acc_valid;
    ifxi_irl_sync u_sync (
        .i_clk   (I_CLK_SYS),
        .i_srst  (I_SRST),
        .i_level (I_INTERRUPT_REQUEST_LEVEL),
        .o_level (acc_level),
        .o_valid (acc_valid)
    );

    logic [31:0] ctrl;
    logic [1:0]  fp_sync;
    logic [1:0]  cp_sync;
    logic        fp_acked;
    logic        cp_acked;
    ifxi_state_e state;
    logic [3:0]  slip_level;
    logic [31:0] slip_r17;
    logic [31:0] slip_r18;
    logic [1:0]  next_fp_sync;
    logic [1:0]  next_cp_sync;
    logic        next_fp_acked;
    logic        next_cp_acked;
    ifxi_state_e next_state;
    logic [3:0]  next_slip_level;
    logic [31:0] next_slip_r17;
    logic [31:0] next_slip_r18;
    logic        next_int_ack;
    logic        next_fp_ack;
    logic        next_cp_ack;
    logic        next_taken;
    logic [7:0]  next_tt;
    logic [31:0] next_r17;
    logic [31:0] next_r18;
    logic        trap_enable;
    logic [3:0]  processor_interrupt_level;
    logic        int_req;
    logic        fp_trap;
    logic        cp_trap;
    logic        advance;

    assign trap_enable = ctrl[CTRL_TRAP_ENABLE_BIT];
    assign processor_interrupt_level         = ctrl[CTRL_PIL_LSB +: 4];
    assign int_req = trap_enable && acc_valid && acc_level != LEVEL_NONE
                   && (acc_level == LEVEL_NMI || acc_level > processor_interrupt_level);
    // fp/cp pins are active low and asynchronous; the second flop is the one read
    assign fp_trap = fp_sync[1] && !fp_acked && I_FP_INSTR;
    assign cp_trap = cp_sync[1] && !cp_acked && I_CP_INSTR;
    // an execute stage that completes without a hold is the only decision point
    assign advance = I_EXEC_DONE && !I_HOLD;

    always_comb begin
        next_fp_sync    = {fp_sync[0], !I_FP_EXCEPTION_REQUEST_N};
        next_cp_sync    = {cp_sync[0], !I_CP_EXCEPTION_REQUEST_N};
        // set wins: a take in the same cycle as the pending drop stays marked
        next_fp_acked   = fp_acked && fp_sync[1];
        next_cp_acked   = cp_acked && cp_sync[1];
        next_state      = state;
        next_slip_level = slip_level;
        next_slip_r17   = slip_r17;
        next_slip_r18   = slip_r18;
        next_int_ack    = 1'b0;
        next_fp_ack     = 1'b0;
        next_cp_ack     = 1'b0;
        next_taken      = 1'b0;
        next_tt         = O_TRAP_TYPE;
        next_r17        = O_SAVE_R17;
        next_r18        = O_SAVE_R18;
        case (state)
            ST_IDLE: begin
                if (advance && fp_trap) begin
                    next_fp_ack   = 1'b1;
                    next_fp_acked = 1'b1;
                    next_taken    = 1'b1;
                    next_tt       = TT_FP_EXC;
                    next_r17      = I_EXEC_PC;
                    next_r18      = I_EXEC_NPC;
                end else if (advance && cp_trap) begin
                    next_cp_ack   = 1'b1;
                    next_cp_acked = 1'b1;
                    next_taken    = 1'b1;
                    next_tt       = TT_CP_EXC;
                    next_r17      = I_EXEC_PC;
                    next_r18      = I_EXEC_NPC;
                end else if (advance && !I_SYNC_TRAP && int_req) begin
                    if (I_ANNUL_BRANCH) begin
                        next_state      = ST_SLIP;
                        next_slip_level = acc_level;
                        // the annulled slot is skipped, so it is never the saved pc
                        next_slip_r17   = I_BRANCH_TAKEN ? I_TARGET_PC : I_BRANCH_PC;
                        next_slip_r18   = I_BRANCH_TAKEN ? step(I_TARGET_PC)
                                                         : step(I_BRANCH_PC);
                    end else begin
                        next_int_ack = 1'b1;
                        next_taken   = 1'b1;
                        next_tt      = TT_INT_BASE + {4'h0, acc_level};
                        next_r17     = I_EXEC_PC;
                        next_r18     = I_BRANCH_TAKEN ? I_TARGET_PC : I_EXEC_NPC;
                    end
                end
            end
            ST_SLIP: begin
                if (!I_HOLD) begin
                    next_state   = ST_IDLE;
                    next_int_ack = 1'b1;
                    next_taken   = 1'b1;
                    next_tt      = TT_INT_BASE + {4'h0, slip_level};
                    next_r17     = slip_r17;
                    next_r18     = slip_r18;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            fp_sync                    <= 2'h0;
            cp_sync                    <= 2'h0;
            fp_acked                   <= 1'b0;
            cp_acked                   <= 1'b0;
            state                      <= ST_IDLE;
            slip_level                 <= LEVEL_NONE;
            slip_r17                   <= 32'h0000_0000;
            slip_r18                   <= 32'h0000_0000;
            O_INTERRUPT_ACKNOWLEDGE    <= 1'b0;
            O_FP_EXCEPTION_ACKNOWLEDGE <= 1'b0;
            O_CP_EXCEPTION_ACKNOWLEDGE <= 1'b0;
            O_TRAP_TAKEN               <= 1'b0;
            O_TRAP_TYPE                <= 8'h00;
            O_SAVE_R17                 <= 32'h0000_0000;
            O_SAVE_R18                 <= 32'h0000_0000;
        end else begin
            fp_sync                    <= next_fp_sync;
            cp_sync                    <= next_cp_sync;
            fp_acked                   <= next_fp_acked;
            cp_acked                   <= next_cp_acked;
            state                      <= next_state;
            slip_level                 <= next_slip_level;
            slip_r17                   <= next_slip_r17;
            slip_r18                   <= next_slip_r18;
            O_INTERRUPT_ACKNOWLEDGE    <= next_int_ack;
            O_FP_EXCEPTION_ACKNOWLEDGE <= next_fp_ack;
            O_CP_EXCEPTION_ACKNOWLEDGE <= next_cp_ack;
            O_TRAP_TAKEN               <= next_taken;
            O_TRAP_TYPE                <= next_tt;
            O_SAVE_R17                 <= next_r17;
            O_SAVE_R18                 <= next_r18;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: address and data held independently, one write and one read at a time
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_full;
    logic        next_w_full;
    logic [7:0]  next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic [31:0] next_ctrl;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_arvalid_ok;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [31:0] status;

    always_comb begin
        status = 32'h0000_0000;
        status[STAT_LEVEL_LSB +: 4] = acc_level;
        status[STAT_VALID_BIT]      = acc_valid;
        status[STAT_INT_REQ_BIT]    = int_req;
        status[STAT_FP_PEND_BIT]    = fp_sync[1];
        status[STAT_CP_PEND_BIT]    = cp_sync[1];
        status[STAT_SLIP_BIT]       = (state == ST_SLIP);
    end

    always_comb begin
        next_aw_full = aw_full || (I_AWVALID && O_AWREADY);
        next_w_full  = w_full || (I_WVALID && O_WREADY);
        next_aw_addr = (I_AWVALID && O_AWREADY) ? I_AWADDR : aw_addr;
        next_w_data  = (I_WVALID && O_WREADY) ? I_WDATA : w_data;
        next_w_strb  = (I_WVALID && O_WREADY) ? I_WSTRB : w_strb;
        next_ctrl    = ctrl;
        next_bvalid  = O_BVALID && !I_BREADY;
        next_bresp   = O_BRESP;
        if (aw_full && w_full && !O_BVALID) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_SLVERR;
            if (decode(aw_addr) == SEL_CTRL) begin
                next_bresp = RESP_OKAY;
                if (w_strb[0]) begin
                    next_ctrl[7:0] = w_data[7:0];
                end
            end
        end
        next_rvalid     = O_RVALID && !I_RREADY;
        next_rdata      = O_RDATA;
        next_rresp      = O_RRESP;
        next_arvalid_ok = I_ARVALID && O_ARREADY;
        if (next_arvalid_ok) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (decode(I_ARADDR))
                SEL_CTRL:   next_rdata = ctrl;
                SEL_STATUS: next_rdata = status;
                SEL_PC:     next_rdata = O_SAVE_R17;
                SEL_NPC:    next_rdata = O_SAVE_R18;
                SEL_TT:     next_rdata = {24'h00_0000, O_TRAP_TYPE};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            ctrl      <= CTRL_RESET;
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            O_BVALID  <= 1'b0;
            O_BRESP   <= RESP_OKAY;
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h0000_0000;
            O_RRESP   <= RESP_OKAY;
        end else begin
            aw_full   <= next_aw_full;
            w_full    <= next_w_full;
            aw_addr   <= next_aw_addr;
            w_data    <= next_w_data;
            w_strb    <= next_w_strb;
            ctrl      <= next_ctrl;
            O_AWREADY <= !next_aw_full && !next_bvalid;
            O_WREADY  <= !next_w_full && !next_bvalid;
            O_BVALID  <= next_bvalid;
            O_BRESP   <= next_bresp;
            O_ARREADY <= !next_rvalid;
            O_RVALID  <= next_rvalid;
            O_RDATA   <= next_rdata;
            O_RRESP   <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);

    ack_pulse_a: assert property (O_INTERRUPT_ACKNOWLEDGE |=> !O_INTERRUPT_ACKNOWLEDGE)
        else $error("interrupt acknowledge longer than one cycle");
    nmi_take_a: assert property (state == ST_IDLE && advance && !fp_trap && !cp_trap
        && !I_SYNC_TRAP && !I_ANNUL_BRANCH && trap_enable && acc_valid
        && acc_level == LEVEL_NMI |=> O_INTERRUPT_ACKNOWLEDGE && O_TRAP_TYPE == 8'h1F)
        else $error("non-maskable level not taken");
    level_mask_a: assert property (O_INTERRUPT_ACKNOWLEDGE && state == ST_IDLE
        && $past(state) == ST_IDLE |-> O_TRAP_TYPE > 8'h10
        && ($past(acc_level) == LEVEL_NMI || $past(acc_level) > $past(processor_interrupt_level)))
        else $error("interrupt taken at or below pil");
    annul_slip_a: assert property (state == ST_IDLE && advance && int_req
        && !fp_trap && !cp_trap && !I_SYNC_TRAP && I_ANNUL_BRANCH
        ##1 !I_HOLD |-> !O_INTERRUPT_ACKNOWLEDGE ##1 O_INTERRUPT_ACKNOWLEDGE)
        else $error("annulled branch slip not one cycle");
    sync_wins_a: assert property (state == ST_IDLE && I_SYNC_TRAP
        |=> !O_INTERRUPT_ACKNOWLEDGE)
        else $error("interrupt taken over a synchronous trap");
    fp_defer_a: assert property (O_FP_EXCEPTION_ACKNOWLEDGE |->
        $past(I_FP_INSTR) && $past(advance) && O_TRAP_TYPE == TT_FP_EXC)
        else $error("fp exception taken without an fp instruction");
    cp_take_a: assert property (state == ST_IDLE && advance && cp_trap && !fp_trap
        |=> O_CP_EXCEPTION_ACKNOWLEDGE && O_TRAP_TAKEN)
        else $error("cp exception not taken");
    annul_save_a: assert property (O_INTERRUPT_ACKNOWLEDGE && $past(state) == ST_SLIP
        |-> O_SAVE_R18 == step(O_SAVE_R17))
        else $error("annulled branch saved pair not consecutive");
    et_gate_a: assert property (O_INTERRUPT_ACKNOWLEDGE |->
        $past(trap_enable) || $past(trap_enable, 2))
        else $error("interrupt taken with traps disabled");

    cover property (O_INTERRUPT_ACKNOWLEDGE && $past(state) == ST_IDLE);
    cover property (O_INTERRUPT_ACKNOWLEDGE && $past(state) == ST_SLIP);
    cover property (O_FP_EXCEPTION_ACKNOWLEDGE);
    cover property (O_CP_EXCEPTION_ACKNOWLEDGE);
endmodule

// >>> verilog/ifxi_irl_sync.sv
// request level synchroniser with agreement filter
`timescale 1ns/10ps
module ifxi_irl_sync
    import ifxi_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic [3:0] i_level,
    output logic      [3:0] o_level,
    output logic            o_valid
);
    // meta flop first, so the comparison never looks at a possibly metastable flop
    logic [3:0] meta;
    logic [3:0] stage_a;
    logic [3:0] stage_b;
    logic [3:0] next_meta;
    logic [3:0] next_stage_a;
    logic [3:0] next_stage_b;
    logic [3:0] next_level;
    logic       next_valid;

    always_comb begin
        next_meta    = i_level;
        next_stage_a = meta;
        next_stage_b = stage_a;
        next_valid   = (stage_a == stage_b);
        next_level   = (stage_a == stage_b) ? stage_b : LEVEL_NONE;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta    <= LEVEL_NONE;
            stage_a <= LEVEL_NONE;
            stage_b <= LEVEL_NONE;
            o_level <= LEVEL_NONE;
            o_valid <= 1'b0;
        end else begin
            meta    <= next_meta;
            stage_a <= next_stage_a;
            stage_b <= next_stage_b;
            o_level <= next_level;
            o_valid <= next_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sync_agree_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_valid && o_level != LEVEL_NONE |->
            $past(i_level, 3) == o_level && $past(i_level, 4) == o_level)
        else $error("accepted level was not stable on two edges");
endmodule

// >>> verilog/ifxi_pkg.sv
// constants shared by the interrupt and fp/cp exception intake block
package ifxi_pkg;
    // axi4-lite register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_SAVED_PC  = 8'h08;
    localparam logic [7:0] OFS_SAVED_NPC = 8'h0C;
    localparam logic [7:0] OFS_TRAP_TYPE = 8'h10;
    // ctrl fields
    localparam int CTRL_TRAP_ENABLE_BIT = 0;
    localparam int CTRL_PIL_LSB         = 4;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    // status fields
    localparam int STAT_LEVEL_LSB   = 0;
    localparam int STAT_VALID_BIT   = 4;
    localparam int STAT_INT_REQ_BIT = 5;
    localparam int STAT_FP_PEND_BIT = 6;
    localparam int STAT_CP_PEND_BIT = 7;
    localparam int STAT_SLIP_BIT    = 8;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // interrupt levels and trap types
    localparam logic [3:0] LEVEL_NONE    = 4'h0;
    localparam logic [3:0] LEVEL_NMI     = 4'hF;
    localparam logic [7:0] TT_INT_BASE   = 8'h10;
    localparam logic [7:0] TT_FP_EXC     = 8'h08;
    localparam logic [7:0] TT_CP_EXC     = 8'h28;
    localparam logic [31:0] PC_STEP      = 32'h0000_0004;
    // register selector codes
    typedef enum logic [2:0] {
        SEL_CTRL   = 3'b000,
        SEL_STATUS = 3'b001,
        SEL_PC     = 3'b010,
        SEL_NPC    = 3'b011,
        SEL_TT     = 3'b100,
        SEL_NONE   = 3'b111
    } ifxi_sel_e;
    // interrupt take sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SLIP = 2'b01
    } ifxi_state_e;
endpackage
